// file: core/frdc_bus_if.sv
/*
  Memory bus between the host controller and the flash configuration logic.
  Assumes both ends run on the same clock; the testbench joins them.
*/
`timescale 1ns/1ps
`default_nettype none

interface frdc_bus_if #(
  parameter int ADDR_W = 24
);
  logic [ADDR_W-1:0] addr;   // partition in top bits, offset/value below
  logic [15:0]       wdata;  // command code of a write
  logic [15:0]       rdata;  // read answer
  logic              we;     // write strobe, one cycle
  logic              re;     // read strobe, one cycle
  logic              rvalid; // read answer valid, one cycle

  modport device (input addr, wdata, we, re, output rdata, rvalid);
  modport host   (output addr, wdata, we, re, input rdata, rvalid);
endinterface : frdc_bus_if

`default_nettype wire

// file: core/frdc_cfg_reg.sv
/*
  One volatile 16-bit configuration register with a load strobe.
  Assumes the loading logic runs on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module frdc_cfg_reg #(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  // load side
  input  wire logic        load_in,
  input  wire logic [15:0] value_in,
  // stored value
  output logic      [15:0] value_out
);

  // holds its reset value until loaded
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      value_out <= RESET_VAL;
    end else if (load_in) begin
      value_out <= value_in;
    end
  end

endmodule : frdc_cfg_reg

`default_nettype wire

// file: core/frdc_defines.svh
/*
  Constants of the flash read and drive configuration block: command codes,
  identification offsets, reset values, field positions and code limits.
  Assumes it is included by its bare name before the package and modules.
*/
`ifndef FRDC_DEFINES_SVH
`define FRDC_DEFINES_SVH

// command codes carried on the data lines
`define FRDC_CMD_CFG_SETUP     16'h0060
`define FRDC_CMD_READ_CONFIRM  16'h0003
`define FRDC_CMD_DRIVE_CONFIRM 16'h0004
`define FRDC_CMD_IDENT_MODE    16'h0090
`define FRDC_CMD_READ_ARRAY    16'h00FF
`define FRDC_CMD_READ_STATUS   16'h0070

// offsets within a partition in identification read mode
`define FRDC_OFS_MAKER     16'h0000
`define FRDC_OFS_READ_CFG  16'h0005
`define FRDC_OFS_DRIVE_CFG 16'h0006

// reset and fixed values
`define FRDC_READ_CFG_RESET  16'hBFCF
`define FRDC_DRIVE_CFG_RESET 16'h0004
`define FRDC_STATUS_READY    16'h0080
`define FRDC_ZERO_WORD       16'h0000

// writable bits, reserved bits cleared by the host
`define FRDC_READ_CFG_WMASK  16'hFD07
`define FRDC_DRIVE_CFG_WMASK 16'h0007

// read and drive configuration field positions
`define FRDC_MODE_BIT     15
`define FRDC_LAT_HI       14
`define FRDC_LAT_LO       11
`define FRDC_WAIT_POL_BIT 10
`define FRDC_WAIT_DLY_BIT 8
`define FRDC_BURST_HI     2
`define FRDC_BURST_LO     0
`define FRDC_DRIVE_HI     2
`define FRDC_DRIVE_LO     0

// code limits and encodings
`define FRDC_LAT_MIN     4'h3
`define FRDC_LAT_MAX     4'hD
`define FRDC_BURST_8     3'h2
`define FRDC_BURST_16    3'h3
`define FRDC_BURST_CONT  3'h7
`define FRDC_WORDS_8     5'h08
`define FRDC_WORDS_16    5'h10
`define FRDC_WORDS_NONE  5'h00

// drive codes and their impedance in ohms
`define FRDC_OHMS_1 7'h5A
`define FRDC_OHMS_2 7'h3C
`define FRDC_OHMS_3 7'h2D
`define FRDC_OHMS_4 7'h1E
`define FRDC_OHMS_5 7'h14
`define FRDC_OHMS_6 7'h0F
`define FRDC_OHMS_NONE 7'h00

`endif

// file: core/frdc_device.sv
/*
  Device end: read and drive configuration registers of a partitioned flash,
  their two-cycle programming sequences, per-partition read modes and the
  identification read-back, plus decoded configuration outputs.
  Assumes the host keeps its own obligations and shares the device clock.
*/
//
// Overview of operation
// - read configuration is volatile sixteen bit register
// - identification mode offset five returns read configuration
// - reset gives BFCF; asynchronous mode ignores other bits
// - bit fifteen: zero synchronous, one asynchronous
// - bits fourteen to eleven: latency three..thirteen
// - host picks latency fitting its clock
// - bit ten sets wait output polarity
// - bit eight releases wait one clock early
// - host writes zero into reserved read bits
// - bits two to zero select burst length
// - read programming: setup 0060 then confirm 0003
// - setup write switches partition to status mode
// - confirm loads register, partition returns array mode
// - host compensates address wiring offsets
// - host never fetches while changing read mode
// - drive configuration register resets to 0004
// - drive bits set data and wait strength
// - drive codes map to ninety..fifteen ohms
// - drive programming: setup 0060 then confirm 0004
// - write 0090 enters identification read mode
// - all partitions start in array mode
`timescale 1ns/1ps
`default_nettype none
`include "frdc_defines.svh"

module frdc_device
  import frdc_pkg::*;
#(
  parameter int          ADDR_W     = 24,
  parameter int          PART_W     = 3,
  parameter logic [15:0] MAKER_CODE = 16'h00A5 // arbitrary value
) (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  // memory bus
  frdc_bus_if.device       bus,
  // register contents
  output logic      [15:0] read_cfg_out,
  output logic      [15:0] drive_cfg_out,
  // decoded read configuration
  output logic             sync_mode_out,
  output logic      [3:0]  latency_out,
  output logic             wait_active_high_out,
  output logic             wait_early_out,
  output logic             burst_wrap_out,
  output logic      [4:0]  burst_words_out,
  // decoded drive configuration
  output logic      [6:0]  drive_ohms_out,
  // unsupported setting present
  output logic             cfg_unsupported_out
);

  localparam int NPART = 1 << PART_W;

  // stored registers
  logic [15:0]        read_cfg;             // read configuration value
  logic [15:0]        drive_cfg;            // drive configuration value
  logic               pend;                 // setup taken, confirm awaited
  logic [PART_W-1:0]  pend_part;            // partition of the setup write
  frdc_read_mode_t    part_mode [NPART];    // read mode per partition

  // bus field decode
  wire  [PART_W-1:0]  part  = bus.addr[ADDR_W-1 -: PART_W];
  wire  [15:0]        a_val = bus.addr[15:0]; // value or offset field

  // write command decode
  wire is_setup = bus.we && (bus.wdata == `FRDC_CMD_CFG_SETUP);
  wire is_rconf = bus.we && pend && (pend_part == part)
                  && (bus.wdata == `FRDC_CMD_READ_CONFIRM);
  wire is_dconf = bus.we && pend && (pend_part == part)
                  && (bus.wdata == `FRDC_CMD_DRIVE_CONFIRM);
  wire is_bad   = bus.we && pend && !is_rconf && !is_dconf;
  wire is_id    = bus.we && !pend && (bus.wdata == `FRDC_CMD_IDENT_MODE);
  wire is_array = bus.we && !pend && (bus.wdata == `FRDC_CMD_READ_ARRAY);
  wire is_stat  = bus.we && !pend && (bus.wdata == `FRDC_CMD_READ_STATUS);

  // next read mode of the addressed partition
  frdc_read_mode_t next_mode;
  assign next_mode = (is_rconf || is_dconf) ? frdc_mode_array :
                     is_bad   ? frdc_mode_status :
                     is_setup ? frdc_mode_status :
                     is_id    ? frdc_mode_ident :
                     is_array ? frdc_mode_array :
                     is_stat  ? frdc_mode_status :
                     part_mode[part];

  // configuration registers, loaded from the confirm address bits
  frdc_cfg_reg #(
    .RESET_VAL (`FRDC_READ_CFG_RESET)
  ) u_read_cfg (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .load_in     (is_rconf),
    .value_in    (a_val),
    .value_out   (read_cfg)
  );

  frdc_cfg_reg #(
    .RESET_VAL (`FRDC_DRIVE_CFG_RESET)
  ) u_drive_cfg (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .load_in     (is_dconf),
    .value_in    (a_val),
    .value_out   (drive_cfg)
  );

  // pending setup tracking; any write ends it, and a setup write starts it only when none is pending
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend      <= 1'b0;
      pend_part <= '0;
    end else if (bus.we) begin
      pend      <= is_setup && !pend;
      pend_part <= part;
    end
  end

  // per-partition read mode
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < NPART; i++) begin
        part_mode[i] <= frdc_mode_array;
      end
    end else if (bus.we) begin
      for (int i = 0; i < NPART; i++) begin
        if (PART_W'(i) == part) begin
          part_mode[i] <= next_mode;
        end
      end
    end
  end

  // read data selection by the partition's read mode
  wire [15:0] id_data  = (a_val == `FRDC_OFS_READ_CFG)  ? read_cfg :
                         (a_val == `FRDC_OFS_DRIVE_CFG) ? drive_cfg :
                         (a_val == `FRDC_OFS_MAKER)     ? MAKER_CODE :
                         `FRDC_ZERO_WORD;
  wire [15:0] rd_sel   = (part_mode[part] == frdc_mode_ident)  ? id_data :
                         (part_mode[part] == frdc_mode_status) ? `FRDC_STATUS_READY :
                         `FRDC_ZERO_WORD;  // array data lies outside this block

  // read answer, one cycle after the strobe
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus.rdata  <= `FRDC_ZERO_WORD;
      bus.rvalid <= 1'b0;
    end else begin
      bus.rvalid <= bus.re;
      if (bus.re) begin
        bus.rdata <= rd_sel;
      end
    end
  end

  // field decode of the read and drive configuration
  wire       sync_sel = !read_cfg[`FRDC_MODE_BIT];
  wire [3:0] lat      = read_cfg[`FRDC_LAT_HI:`FRDC_LAT_LO];
  wire [2:0] burst    = read_cfg[`FRDC_BURST_HI:`FRDC_BURST_LO];
  wire [2:0] drv      = drive_cfg[`FRDC_DRIVE_HI:`FRDC_DRIVE_LO];
  wire       lat_bad  = (lat < `FRDC_LAT_MIN) || (lat > `FRDC_LAT_MAX);
  wire       bur_bad  = (burst != `FRDC_BURST_8) && (burst != `FRDC_BURST_16)
                        && (burst != `FRDC_BURST_CONT);
  wire       drv_bad  = (drv == 3'h0) || (drv == 3'h7);

  // burst length decode
  wire [4:0] words    = (burst == `FRDC_BURST_8)  ? `FRDC_WORDS_8 :
                        (burst == `FRDC_BURST_16) ? `FRDC_WORDS_16 :
                        `FRDC_WORDS_NONE;
  wire       wrap     = (burst == `FRDC_BURST_8) || (burst == `FRDC_BURST_16);

  // impedance lookup of the drive code
  logic [6:0] ohms;
  always_comb begin
    case (drv)
      3'h1:    ohms = `FRDC_OHMS_1;
      3'h2:    ohms = `FRDC_OHMS_2;
      3'h3:    ohms = `FRDC_OHMS_3;
      3'h4:    ohms = `FRDC_OHMS_4;
      3'h5:    ohms = `FRDC_OHMS_5;
      3'h6:    ohms = `FRDC_OHMS_6;
      default: ohms = `FRDC_OHMS_NONE;  // reserved code
    endcase
  end

  // registered decoded outputs; burst fields apply only in synchronous mode
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      read_cfg_out         <= `FRDC_READ_CFG_RESET;
      drive_cfg_out        <= `FRDC_DRIVE_CFG_RESET;
      sync_mode_out        <= 1'b0;
      latency_out          <= 4'h0;
      wait_active_high_out <= 1'b0;
      wait_early_out       <= 1'b0;
      burst_wrap_out       <= 1'b0;
      burst_words_out      <= `FRDC_WORDS_NONE;
      drive_ohms_out       <= `FRDC_OHMS_4;
      cfg_unsupported_out  <= 1'b0;
    end else begin
      read_cfg_out         <= read_cfg;
      drive_cfg_out        <= drive_cfg;
      sync_mode_out        <= sync_sel;
      latency_out          <= sync_sel ? lat : 4'h0;
      wait_active_high_out <= sync_sel && read_cfg[`FRDC_WAIT_POL_BIT];
      wait_early_out       <= sync_sel && read_cfg[`FRDC_WAIT_DLY_BIT];
      burst_wrap_out       <= sync_sel && wrap;
      burst_words_out      <= sync_sel ? words : `FRDC_WORDS_NONE;
      drive_ohms_out       <= ohms;
      cfg_unsupported_out  <= (sync_sel && (lat_bad || bur_bad)) || drv_bad;
    end
  end

endmodule : frdc_device

`default_nettype wire

// file: core/frdc_host.sv
/*
  Host end: memory controller sequencer that programs and reads back the
  flash configuration registers on user request.
  Assumes the device shares the clock and answers a read one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frdc_defines.svh"

module frdc_host
  import frdc_pkg::*;
#(
  parameter int ADDR_W     = 24,
  parameter int PART_W     = 3,
  parameter int ADDR_SHIFT = 0   // host-to-device address line offset
) (
  // clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  // memory bus
  frdc_bus_if.host               bus,
  // user command port
  input  wire logic              cmd_valid_in,
  input  wire frdc_host_op_t     cmd_op_in,
  input  wire logic [PART_W-1:0] cmd_part_in,
  input  wire logic [15:0]       cmd_value_in,
  output logic                   cmd_ready_out,
  // user answer port
  output logic                   done_out,
  output logic      [15:0]       rd_data_out
);

  frdc_host_state_t  state;     // sequencer state
  frdc_host_op_t     op;        // operation in progress
  logic [PART_W-1:0] op_part;   // target partition
  logic [15:0]       op_value;  // masked value to program

  // place partition and value on the host address lines
  function automatic logic [ADDR_W-1:0] place(input logic [PART_W-1:0] p,
                                              input logic [15:0] v);
    logic [ADDR_W-1:0] a;
    logic [16:0]       s;
    a = '0;
    s = 17'({1'b0, v} << ADDR_SHIFT);
    a[ADDR_W-1 -: PART_W] = p;
    a[16:0] = a[16:0] | s;
    return a;
  endfunction : place

  // value masking and code choice
  wire is_wr     = (cmd_op_in == frdc_op_write_read_cfg)
                   || (cmd_op_in == frdc_op_write_drive_cfg);
  wire [15:0] masked = (cmd_op_in == frdc_op_write_read_cfg)
                   ? (cmd_value_in & `FRDC_READ_CFG_WMASK)
                   : (cmd_value_in & `FRDC_DRIVE_CFG_WMASK);
  wire [15:0] confirm = (op == frdc_op_write_read_cfg)
                   ? `FRDC_CMD_READ_CONFIRM
                   : `FRDC_CMD_DRIVE_CONFIRM;
  wire [15:0] id_ofs = (op == frdc_op_get_read_cfg)
                   ? `FRDC_OFS_READ_CFG : `FRDC_OFS_DRIVE_CFG;

  // sequencer; bus idle during a sequence keeps fetches away
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state         <= frdc_hs_idle;
      op            <= frdc_op_write_read_cfg;
      op_part       <= '0;
      op_value      <= `FRDC_ZERO_WORD;
      bus.addr      <= '0;
      bus.wdata     <= `FRDC_ZERO_WORD;
      bus.we        <= 1'b0;
      bus.re        <= 1'b0;
      cmd_ready_out <= 1'b1;
      done_out      <= 1'b0;
      rd_data_out   <= `FRDC_ZERO_WORD;
    end else begin
      done_out <= 1'b0;
      case (state)
        frdc_hs_idle: begin
          if (cmd_valid_in) begin
            op            <= cmd_op_in;
            op_part       <= cmd_part_in;
            op_value      <= masked;
            cmd_ready_out <= 1'b0;
            bus.we        <= 1'b1;
            if (is_wr) begin
              // setup write with the value on the address lines
              bus.addr  <= place(cmd_part_in, masked);
              bus.wdata <= `FRDC_CMD_CFG_SETUP;
              state     <= frdc_hs_setup;
            end else begin
              // enter identification read mode
              bus.addr  <= place(cmd_part_in, `FRDC_ZERO_WORD);
              bus.wdata <= `FRDC_CMD_IDENT_MODE;
              state     <= frdc_hs_id_cmd;
            end
          end
        end
        frdc_hs_setup: begin
          // confirm write repeats the value on the same lines
          bus.addr  <= place(op_part, op_value);
          bus.wdata <= confirm;
          state     <= frdc_hs_confirm;
        end
        frdc_hs_confirm: begin
          bus.we        <= 1'b0;
          done_out      <= 1'b1;
          cmd_ready_out <= 1'b1;
          state         <= frdc_hs_idle;
        end
        frdc_hs_id_cmd: begin
          bus.we   <= 1'b0;
          bus.re   <= 1'b1;
          bus.addr <= place(op_part, id_ofs);
          state    <= frdc_hs_id_wait;
        end
        frdc_hs_id_wait: begin
          bus.re <= 1'b0;
          if (bus.rvalid) begin
            // capture, then return the partition to array mode
            rd_data_out <= bus.rdata;
            bus.we      <= 1'b1;
            bus.addr    <= place(op_part, `FRDC_ZERO_WORD);
            bus.wdata   <= `FRDC_CMD_READ_ARRAY;
            state       <= frdc_hs_exit;
          end
        end
        frdc_hs_exit: begin
          bus.we        <= 1'b0;
          done_out      <= 1'b1;
          cmd_ready_out <= 1'b1;
          state         <= frdc_hs_idle;
        end
        default: begin
          state <= frdc_hs_idle;
        end
      endcase
    end
  end

endmodule : frdc_host

`default_nettype wire

// file: core/frdc_pkg.sv
/*
  Types shared by both ends: partition read modes, host operations and
  host sequencer states.
  Assumes frdc_defines.svh sits on the include path.
*/
`default_nettype none

package frdc_pkg;

  // read mode of one partition
  typedef enum logic [1:0] {
    frdc_mode_array,
    frdc_mode_status,
    frdc_mode_ident
  } frdc_read_mode_t;

  // operations the host user side may request
  typedef enum logic [1:0] {
    frdc_op_write_read_cfg,
    frdc_op_write_drive_cfg,
    frdc_op_get_read_cfg,
    frdc_op_get_drive_cfg
  } frdc_host_op_t;

  // host sequencer states
  typedef enum logic [2:0] {
    frdc_hs_idle,
    frdc_hs_setup,
    frdc_hs_confirm,
    frdc_hs_id_cmd,
    frdc_hs_id_wait,
    frdc_hs_exit
  } frdc_host_state_t;

endpackage : frdc_pkg

`default_nettype wire

// file: sim/frdc_bus_chk.sv
/*
  checker of the memory bus between host and device ends.
  assumes the bench hands it the bus signals, clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none

module frdc_bus_chk #(
  parameter int ADDR_W = 24,
  parameter int PART_W = 3
) (
  // clock and reset
  input wire logic              core_clk_in,
  input wire logic              reset_n_in,
  // bus signals
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [15:0]       wdata_in,
  input wire logic [15:0]       rdata_in,
  input wire logic              we_in,
  input wire logic              re_in,
  input wire logic              rvalid_in
);
  // short local names of the watched bus
  wire [ADDR_W-1:0] addr   = addr_in;
  wire [15:0]       wdata  = wdata_in;
  wire [15:0]       rdata  = rdata_in;
  wire              we     = we_in;
  wire              re     = re_in;
  wire              rvalid = rvalid_in;
  wire [PART_W-1:0] part;     // addressed partition
  wire              is_setup; // setup write seen
  wire              ld_ok;    // confirm to pending partition
  logic             pend;     // setup pending
  logic [PART_W-1:0] ppart;   // partition of the setup
  logic [15:0]      rc;       // expected read config
  logic [15:0]      dc;       // expected drive config

  assign part     = addr[ADDR_W-1 -: PART_W];
  assign is_setup = we && wdata == 16'h0060;
  assign ld_ok    = we && pend && ppart == part;

  // shadow of both registers, loaded by accepted confirms
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend  <= 1'b0;
      ppart <= '0;
      rc    <= 16'hBFCF;
      dc    <= 16'h0004;
    end else if (we) begin
      pend  <= !pend && is_setup;
      ppart <= part;
      if (ld_ok && wdata == 16'h0003) rc <= addr[15:0];
      if (ld_ok && wdata == 16'h0004) dc <= addr[15:0];
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  chk_read_answer_time: assert property (re |=> rvalid)
    else $error("read answer missing one cycle after strobe");
  chk_answer_has_cause: assert property (rvalid |-> $past(re))
    else $error("read answer without read strobe");
  chk_ident_read_cfg: assert property (
    (we && wdata == 16'h0090) ##1 (re && addr[15:0] == 16'h0005 && part == $past(part))
    |=> rdata == rc) else $error("read config readback wrong");
  chk_ident_drive_cfg: assert property (
    (we && wdata == 16'h0090) ##1 (re && addr[15:0] == 16'h0006 && part == $past(part))
    |=> rdata == dc) else $error("drive config readback wrong");
  chk_confirm_code: assert property (is_setup |=> we && part == $past(part) &&
    (wdata == 16'h0003 || wdata == 16'h0004)) else $error("setup not followed by confirm");
  chk_confirm_same_addr: assert property (is_setup |=> $stable(addr))
    else $error("confirm value differs from setup value");
  chk_strobe_exclusive: assert property (!(we && re))
    else $error("write and read strobe together");
  chk_read_reserved_zero: assert property (
    $past(is_setup) && we && wdata == 16'h0003 |-> (addr[15:0] & 16'h02F8) == 16'h0000)
    else $error("reserved read config bits set");
  chk_drive_reserved_zero: assert property (
    $past(is_setup) && we && wdata == 16'h0004 |-> (addr[15:0] & 16'hFFF8) == 16'h0000)
    else $error("reserved drive config bits set");
endmodule : frdc_bus_chk

`default_nettype wire

// file: sim/tb.sv
/*
  bench: host and device ends joined by the bus, driven at the host user port.
  assumes the core files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import frdc_pkg::*;
  // clock, reset and user port
  logic          core_clk_in = 1'b0;
  logic          reset_n_in  = 1'b0;
  logic          cmd_valid   = 1'b0;
  frdc_host_op_t cmd_op      = frdc_op_get_read_cfg;
  logic [2:0]    cmd_part    = 3'h0;
  logic [15:0]   cmd_value   = 16'h0000;
  // host answers
  logic          cmd_ready;
  logic          done;
  logic [15:0]   rd_data;
  // device outputs
  logic [15:0]   rcfg;
  logic [15:0]   dcfg;
  logic          sync;
  logic [3:0]    lat;
  logic          wpol;
  logic          wearly;
  logic          wrap;
  logic [4:0]    words;
  logic [6:0]    ohms;
  logic          unsup;
  // bookkeeping
  int            num_errors  = 0;
  int            check_count = 0;
  int            cycles      = 0;
  logic [15:0]   exp_q[$];
  logic [15:0]   cur_rc;
  logic [15:0]   cur_dc;
  logic          last_get    = 1'b0;
  logic [6:0]    ohm_tab [8] = '{7'h00, 7'h5A, 7'h3C, 7'h2D, 7'h1E, 7'h14, 7'h0F, 7'h00};
  logic [15:0]   rc_tab [8]  = '{16'h1807, 16'h6802, 16'h6D03, 16'h1000,
                                 16'h7002, 16'h3F00, 16'h3BFF, 16'hFFFF};

  // free running clock
  always #5 core_clk_in = ~core_clk_in;

  frdc_bus_if #(.ADDR_W(24)) fbus ();

  frdc_device frdc_device_inst (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .bus(fbus),
    .read_cfg_out(rcfg), .drive_cfg_out(dcfg), .sync_mode_out(sync),
    .latency_out(lat), .wait_active_high_out(wpol), .wait_early_out(wearly),
    .burst_wrap_out(wrap), .burst_words_out(words), .drive_ohms_out(ohms),
    .cfg_unsupported_out(unsup));

  frdc_host frdc_host_inst (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .bus(fbus),
    .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_part_in(cmd_part),
    .cmd_value_in(cmd_value), .cmd_ready_out(cmd_ready), .done_out(done),
    .rd_data_out(rd_data));

  frdc_bus_chk frdc_bus_chk_inst (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .addr_in(fbus.addr),
    .wdata_in(fbus.wdata), .rdata_in(fbus.rdata), .we_in(fbus.we), .re_in(fbus.re),
    .rvalid_in(fbus.rvalid));

  // one comparison of a 16-bit value
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // register contents and decoded fields against the expected registers
  task automatic check_outputs();
    logic       s;
    logic [2:0] b;
    logic       bad;
    s   = ~cur_rc[15];
    b   = cur_rc[2:0];
    bad = s && (cur_rc[14:11] < 4'h3 || cur_rc[14:11] > 4'hD || !(b inside {3'h2, 3'h3, 3'h7}));
    bad = bad || ohm_tab[cur_dc[2:0]] == 7'h00;
    cmp("read_cfg_out", cur_rc, rcfg);
    cmp("drive_cfg_out", cur_dc, dcfg);
    cmp("sync_mode_out", {15'h0, s}, {15'h0, sync});
    cmp("latency_out", {12'h0, s ? cur_rc[14:11] : 4'h0}, {12'h0, lat});
    cmp("wait_polarity", {15'h0, s & cur_rc[10]}, {15'h0, wpol});
    cmp("wait_early", {15'h0, s & cur_rc[8]}, {15'h0, wearly});
    cmp("burst_wrap", {15'h0, s && b inside {3'h2, 3'h3}}, {15'h0, wrap});
    cmp("burst_words", {11'h0, !s ? 5'h00 : b == 3'h2 ? 5'h08 : b == 3'h3 ? 5'h10 : 5'h00},
        {11'h0, words});
    cmp("drive_ohms", {9'h0, ohm_tab[cur_dc[2:0]]}, {9'h0, ohms});
    cmp("unsupported", {15'h0, bad}, {15'h0, unsup});
  endtask : check_outputs

  // one user command, expectation noted first, outputs checked after
  task automatic run_cmd(input frdc_host_op_t op, input logic [2:0] p, input logic [15:0] v);
    int n;
    if (op == frdc_op_write_read_cfg) cur_rc = v & 16'hFD07;
    if (op == frdc_op_write_drive_cfg) cur_dc = v & 16'h0007;
    if (op == frdc_op_get_read_cfg) exp_q.push_back(cur_rc);
    if (op == frdc_op_get_drive_cfg) exp_q.push_back(cur_dc);
    @(posedge core_clk_in);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_part  <= p;
    cmd_value <= v;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (cmd_ready !== 1'b1 && n < 20);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (done !== 1'b1 && n < 20);
    if (done !== 1'b1) begin
      num_errors++;
      $display("wrong value done_out expected 1 seen %b", done);
    end
    repeat (2) @(posedge core_clk_in);
    check_outputs();
  endtask : run_cmd

  // reset held five cycles, defaults expected afterwards
  task automatic do_reset();
    @(posedge core_clk_in);
    reset_n_in <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    @(posedge core_clk_in);
    cur_rc = 16'hBFCF;
    cur_dc = 16'h0004;
    check_outputs();
  endtask : do_reset

  // closing report and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // result watcher: each get answer against the oldest note
  always @(posedge core_clk_in) begin
    if (reset_n_in && done === 1'b1 && last_get) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("wrong value rd_data_out expected no answer seen %h", rd_data);
      end else begin
        cmp("rd_data_out", exp_q.pop_front(), rd_data);
      end
    end
    if (cmd_valid && cmd_ready === 1'b1) last_get = cmd_op[1];
  end

  // hang guard
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles >= 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  // main sequence
  initial begin
    void'($urandom(32'h92b0));
    do_reset();
    run_cmd(frdc_op_get_read_cfg, 3'h0, 16'h0000);
    run_cmd(frdc_op_get_drive_cfg, 3'h7, 16'h0000);
    // field boundaries, reserved codes and every drive code
    // no burst fetch ever follows, so low latency codes suit this clock
    for (int i = 0; i < 8; i++) begin
      run_cmd(frdc_op_write_read_cfg, i[2:0], rc_tab[i]);
      run_cmd(frdc_op_write_drive_cfg, 3'h2, i[15:0]);
      run_cmd(frdc_op_get_read_cfg, i[2:0], 16'h0000);
    end
    // random operations, partitions and values
    for (int i = 0; i < 40; i++) begin
      run_cmd(frdc_host_op_t'($urandom_range(3)), 3'($urandom), 16'($urandom));
    end
    // reset in mid-run restores defaults
    run_cmd(frdc_op_write_read_cfg, 3'h1, 16'h3902);
    do_reset();
    run_cmd(frdc_op_get_read_cfg, 3'h1, 16'h0000);
    run_cmd(frdc_op_get_drive_cfg, 3'h1, 16'h0000);
    give_verdict();
  end
endmodule : tb

`default_nettype wire
